// >>> hw/flow_monitor_consts.vh
// Functional notes
// - Fold each executed word except checkpoint and zero set-high into checksum by XOR.
// - Signature is upper half XOR lower half.
// - Checkpoint is set-high to g0 tagged 011111.
// - Clear checksum after every signature comparison.
// - Mismatch raises program-flow trap, code 66H.
// - Trap taken or trap return disarms next check.
// - Zero set-high to g0: no compare, clear, disarm.
// - Disarmed checkpoint reports nothing, then rearms cleared.
// - Monitor on when enable low; checksum resets zero.
// - Delay-slot words counted even when annulled.
// - All parity is odd parity.
// - Check parity only on words actually used.
// - Parity checking suppressed during reset.
// - Coprocessor control signals carry no parity.
// - Fault output held low through trap, handler and resume.
// - Clean resume of failing instruction releases fault.
// - Error with traps disabled: error mode, halt.
// - Errors other than imprecise reported with failing instruction in execute.
// - Codes 61H, 62H, 63H for precise and late.
// - Imprecise errors 64H; register file errors 65H.
`ifndef FLOW_MONITOR_CONSTS_VH
`define FLOW_MONITOR_CONSTS_VH

// Width of the instruction word and of the folded signature.
`define FM_WORD_W 32
`define FM_SIG_W 16

// Hardware error trap type codes.
`define FM_TT_RESTART_PRECISE 8'h61
`define FM_TT_FATAL_PRECISE 8'h62
`define FM_TT_RESTART_LATE 8'h63
`define FM_TT_IMPRECISE 8'h64
`define FM_TT_REGFILE 8'h65
`define FM_TT_FLOW 8'h66

// Instruction format fields used by the decoder.
`define FM_OP_MSB 31
`define FM_OP_LSB 30
`define FM_OP_SETHI 2'h0
`define FM_OP_ARITH 2'h2
`define FM_RD_MSB 29
`define FM_RD_LSB 25
`define FM_OP2_MSB 24
`define FM_OP2_LSB 22
`define FM_OP2_SETHI 3'h4
`define FM_OP3_MSB 24
`define FM_OP3_LSB 19
`define FM_OP3_RETT 6'h39
`define FM_IMM_MSB 21
`define FM_TAG_LSB 16
`define FM_CHK_TAG 6'h1f
`define FM_EXP_MSB 15

// Reset values.
`define FM_CHECKSUM_RST 32'h0000_0000
`define FM_SIG_RST 16'h0000

`endif

// >>> hw/odd_parity_lanes.v
`timescale 1ns/100ps
`include "flow_monitor_consts.vh"
// Odd parity generation and checking over several independent words.
module odd_parity_lanes #(
  parameter WIDTH = 32,
  parameter LANES = 4
) (
  input wire [LANES*WIDTH-1:0] i_words,
  input wire [LANES-1:0] i_pars,
  input wire [LANES-1:0] i_used,
  input wire i_check_en,
  output wire [LANES-1:0] o_gen,
  output wire [LANES-1:0] o_err
);

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_lane
      // Odd parity: the bit makes the total count of ones odd.
      assign o_gen[g] = ~(^i_words[g*WIDTH +: WIDTH]);
      // An unused word is never judged, so stale data cannot trap.
      assign o_err[g] = i_check_en & i_used[g] & (i_pars[g] != o_gen[g]);
    end
  endgenerate

endmodule // odd_parity_lanes

// >>> hw/signature_accum.v
`timescale 1ns/100ps
`include "flow_monitor_consts.vh"
// Running XOR checksum of executed instruction words and its fold.
module signature_accum #(
  parameter WORD_W = `FM_WORD_W
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_clk_en,
  input wire i_fold,
  input wire i_clear,
  input wire [WORD_W-1:0] i_word,
  output wire [WORD_W/2-1:0] o_signature
);

  // Running checksum register.
  reg [WORD_W-1:0] checksum_q;
  reg [WORD_W-1:0] checksum_d;

  // Clear beats fold so a checkpoint word never enters the next block.
  always @*
  begin
    checksum_d = checksum_q;
    if (i_clear)
    begin
      checksum_d = {WORD_W{1'b0}};
    end
    else if (i_fold)
    begin
      checksum_d = checksum_q ^ i_word;
    end
  end

  // Synchronous reset starts the checksum at zero.
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      checksum_q <= `FM_CHECKSUM_RST;
    end
    else if (i_clk_en)
    begin
      checksum_q <= checksum_d;
    end
  end

  // Fold the upper half onto the lower half.
  assign o_signature = checksum_q[WORD_W-1:WORD_W/2] ^ checksum_q[WORD_W/2-1:0];

endmodule // signature_accum

// >>> hw/flow_signature_parity_monitor.v
`timescale 1ns/100ps
`include "flow_monitor_consts.vh"
// Concurrent error detection for the integer unit: flow signatures,
// operand and bus parity, hardware fault output and error mode.
module flow_signature_parity_monitor #(
  parameter WORD_W = `FM_WORD_W
) (
  // Core clock, synchronous active-low reset, clock enable.
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_clk_en,
  // Low turns program flow monitoring on.
  input wire i_flow_enable_n,
  // Instruction in the execute stage and its bus parity bit.
  input wire i_ex_valid,
  input wire [WORD_W-1:0] i_ex_instr,
  input wire i_ex_instr_par,
  // Load data and whether the executing instruction uses it.
  input wire [WORD_W-1:0] i_load_word,
  input wire i_load_par,
  input wire i_load_used,
  // Register file operands with parity and use flags.
  input wire [WORD_W-1:0] i_rf_a_word,
  input wire i_rf_a_par,
  input wire i_rf_a_used,
  input wire [WORD_W-1:0] i_rf_b_word,
  input wire i_rf_b_par,
  input wire i_rf_b_used,
  // Already qualified errors from control register checks.
  input wire i_fatal_precise_err,
  input wire i_imprecise_err,
  // Words whose outgoing parity is generated here.
  input wire [WORD_W-1:0] i_store_word,
  input wire [WORD_W-1:0] i_addr,
  // Trap logic handshake and trap enable state.
  input wire i_trap_taken,
  input wire i_traps_enabled,
  // Fault and error mode indications.
  output wire o_hw_fault_out_n,
  output wire o_error_mode_n,
  output wire o_halt,
  // Hardware trap request and its type.
  output wire o_trap_req,
  output reg [7:0] o_trap_type,
  // Status of the flow monitor.
  output reg [WORD_W/2-1:0] o_last_signature,
  output reg o_check_armed,
  // Outgoing parity bits.
  output reg o_data_bus_parity,
  output reg o_addr_bus_parity
);

  // One-hot fault handling states.
  localparam [4:0] S_RUN = 5'h01;  // Normal execution.
  localparam [4:0] S_PEND = 5'h02; // Trap requested, not yet taken.
  localparam [4:0] S_HNDL = 5'h04; // Inside the error trap routine.
  localparam [4:0] S_RSM = 5'h08;  // Failing instruction being resumed.
  localparam [4:0] S_ERR = 5'h10;  // Error mode, halted until reset.

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [7:0] trap_type_d;

  // Monitoring level; the enable pin is already synchronous.
  wire flow_on;
  assign flow_on = ~i_flow_enable_n;

  // Nothing executes once the unit has halted in error mode.
  wire ex_go;
  assign ex_go = i_ex_valid & ~state_q[4];

  // Instruction decode of set-high to global zero and trap return.
  wire is_sethi_g0;
  wire is_chkpt;
  wire is_nop;
  wire is_rett;
  wire [WORD_W/2-1:0] expected_sig;

  assign is_sethi_g0 = (i_ex_instr[`FM_OP_MSB:`FM_OP_LSB] == `FM_OP_SETHI)
                     & (i_ex_instr[`FM_OP2_MSB:`FM_OP2_LSB] == `FM_OP2_SETHI)
                     & (i_ex_instr[`FM_RD_MSB:`FM_RD_LSB] == 5'h00);
  // The top six immediate bits tag a checkpoint.
  assign is_chkpt = is_sethi_g0
                  & (i_ex_instr[`FM_IMM_MSB:`FM_TAG_LSB] == `FM_CHK_TAG);
  // An all-zero immediate is the reserved no-operation form.
  assign is_nop = is_sethi_g0 & (i_ex_instr[`FM_IMM_MSB:0] == 22'h00_0000);
  assign is_rett = (i_ex_instr[`FM_OP_MSB:`FM_OP_LSB] == `FM_OP_ARITH)
                 & (i_ex_instr[`FM_OP3_MSB:`FM_OP3_LSB] == `FM_OP3_RETT);
  // The compiler places the expected signature in the low immediate bits.
  assign expected_sig = i_ex_instr[`FM_EXP_MSB:0];

  // Checksum control.  With monitoring on, every valid word but a checkpoint or the no-operation form counts, annulled delay-slot
  // words included, because the pipeline marks them valid.
  wire fold_en;
  wire clear_en;
  wire [WORD_W/2-1:0] signature;

  assign fold_en = ex_go & flow_on & ~is_chkpt & ~is_nop;
  // With monitoring off the checksum is held at zero for a clean start.
  assign clear_en = (ex_go & flow_on & (is_chkpt | is_nop)) | ~flow_on;

  signature_accum #(
    .WORD_W(WORD_W)
  ) u_accum (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_fold(fold_en),
    .i_clear(clear_en),
    .i_word(i_ex_instr),
    .o_signature(signature)
  );

  // A comparison happens only at an armed checkpoint.
  wire do_compare;
  wire flow_err;
  assign do_compare = ex_go & flow_on & is_chkpt & o_check_armed;
  // A disarmed checkpoint is skipped silently.
  assign flow_err = do_compare & (signature != expected_sig);

  // Parity checking of the words the current instruction uses.
  // Coprocessor control pins carry no parity and are not inputs here.
  wire [3:0] chk_used;
  wire [3:0] chk_err;
  wire parity_en;

  assign chk_used = {i_rf_b_used, i_rf_a_used, i_load_used, 1'b1};
  // Checking is off in reset; registers may hold garbage parity.
  assign parity_en = i_rst_n & ex_go;

  odd_parity_lanes #(
    .WIDTH(WORD_W),
    .LANES(4)
  ) u_check (
    .i_words({i_rf_b_word, i_rf_a_word, i_load_word, i_ex_instr}),
    .i_pars({i_rf_b_par, i_rf_a_par, i_load_par, i_ex_instr_par}),
    .i_used(chk_used),
    .i_check_en(parity_en),
    .o_gen(),
    .o_err(chk_err)
  );

  // Outgoing parity for store data and address, never checked.
  wire [1:0] gen_par;

  odd_parity_lanes #(
    .WIDTH(WORD_W),
    .LANES(2)
  ) u_gen (
    .i_words({i_addr, i_store_word}),
    .i_pars(2'h0),
    .i_used(2'h0),
    .i_check_en(1'b0),
    .o_gen(gen_par),
    .o_err()
  );

  // Error classes, all but imprecise judged against the instruction in execute.
  wire err_restart_precise;
  wire err_fatal_precise;
  wire err_restart_late;
  wire err_imprecise;
  wire err_regfile;
  wire any_err;

  assign err_restart_precise = chk_err[0];
  assign err_restart_late = chk_err[1];
  assign err_regfile = chk_err[2] | chk_err[3];
  assign err_fatal_precise = i_fatal_precise_err & ex_go & i_rst_n;
  assign err_imprecise = i_imprecise_err & ~state_q[4] & i_rst_n;
  assign any_err = err_restart_precise | err_fatal_precise | err_restart_late
                 | err_imprecise | err_regfile | flow_err;

  // Pick the trap type; only the most severe error is reported and
  // lower ones are dropped, as the trap logic can take one at a time.
  always @*
  begin
    trap_type_d = `FM_TT_FLOW;
    if (err_imprecise)
    begin
      trap_type_d = `FM_TT_IMPRECISE;
    end
    else if (err_fatal_precise)
    begin
      trap_type_d = `FM_TT_FATAL_PRECISE;
    end
    else if (err_regfile)
    begin
      trap_type_d = `FM_TT_REGFILE;
    end
    else if (err_restart_late)
    begin
      trap_type_d = `FM_TT_RESTART_LATE;
    end
    else if (err_restart_precise)
    begin
      trap_type_d = `FM_TT_RESTART_PRECISE;
    end
  end

  // Fault handling state machine.
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_RUN:
      begin
        // A fault with traps off cannot be serviced: stop the unit.
        if (any_err)
        begin
          state_d = i_traps_enabled ? S_PEND : S_ERR;
        end
      end
      S_PEND:
      begin
        // The fault output and request hold until the trap is taken.
        if (i_trap_taken)
        begin
          state_d = S_HNDL;
        end
      end
      S_HNDL:
      begin
        // Handler runs with traps disabled, so a fault here is fatal.
        if (any_err & ~i_traps_enabled)
        begin
          state_d = S_ERR;
        end
        else if (ex_go & is_rett)
        begin
          state_d = S_RSM;
        end
      end
      S_RSM:
      begin
        // The resumed instruction decides: clean means transient.
        if (any_err)
        begin
          state_d = i_traps_enabled ? S_PEND : S_ERR;
        end
        else if (ex_go)
        begin
          state_d = S_RUN;
        end
      end
      S_ERR:
      begin
        // Only reset leaves error mode.
        state_d = S_ERR;
      end
      default:
      begin
        state_d = S_RUN;
      end
    endcase
  end

  // State, trap type and check arming registers.
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= S_RUN;
      o_trap_type <= 8'h00;
      o_check_armed <= 1'b1;
      o_last_signature <= `FM_SIG_RST;
      o_data_bus_parity <= 1'b1;
      o_addr_bus_parity <= 1'b1;
    end
    else if (i_clk_en)
    begin
      state_q <= state_d;
      // Latch the type only when a new request is raised.
      if (state_d[1] & ~state_q[1])
      begin
        o_trap_type <= trap_type_d;
      end
      // Disarming wins over arming when both happen together.
      if (i_trap_taken | (ex_go & is_rett))
      begin
        o_check_armed <= 1'b0;
      end
      else if (ex_go & flow_on & is_nop)
      begin
        o_check_armed <= 1'b0;
      end
      else if (ex_go & flow_on & is_chkpt)
      begin
        o_check_armed <= 1'b1;
      end
      // Keep the last signature checked for diagnosis.
      if (do_compare)
      begin
        o_last_signature <= signature;
      end
      o_data_bus_parity <= gen_par[0];
      o_addr_bus_parity <= gen_par[1];
    end
  end

  // Request is a level held in its state until the trap is taken.
  assign o_trap_req = state_q[1];
  // Fault output is low from detection through handling and resume,
  // and forever in error mode.
  assign o_hw_fault_out_n = state_q[0];
  assign o_error_mode_n = ~state_q[4];
  assign o_halt = state_q[4];

endmodule // flow_signature_parity_monitor

// >>> tb/trap_logic_model.sv
`timescale 1ns/100ps
// Trap logic of the integer unit: takes a pending hardware trap after a
// programmable number of cycles, so handlers can be prompt or slow.
module trap_logic_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_trap_req,
  input wire logic [3:0] i_delay,
  output logic o_trap_taken
);
  int wait_q; // Cycles the pending request has waited so far.
  // The taken pulse lasts one cycle, because the model clears it at the next edge.
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_trap_taken <= 1'b0;
      wait_q <= 0;
    end
    else if (o_trap_taken)
    begin
      o_trap_taken <= 1'b0;
      wait_q <= 0;
    end
    else if (i_trap_req === 1'b1)
    begin
      if (wait_q >= i_delay)
        o_trap_taken <= 1'b1;
      else
        wait_q <= wait_q + 1;
    end
  end
endmodule // trap_logic_model

// >>> tb/fspm_chk.sv
`timescale 1ns/100ps
// Port-level checks of trap, fault, flow arming and parity outputs.
module fspm_chk #(
  parameter WORD_W = 32
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_flow_enable_n,
  input wire logic i_ex_valid,
  input wire logic [WORD_W-1:0] i_ex_instr,
  input wire logic i_ex_instr_par,
  input wire logic [WORD_W-1:0] i_store_word,
  input wire logic [WORD_W-1:0] i_addr,
  input wire logic i_trap_taken,
  input wire logic i_traps_enabled,
  input wire logic o_hw_fault_out_n,
  input wire logic o_error_mode_n,
  input wire logic o_halt,
  input wire logic o_trap_req,
  input wire logic [7:0] o_trap_type,
  input wire logic o_check_armed,
  input wire logic o_data_bus_parity,
  input wire logic o_addr_bus_parity
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // The request and its type stand until the trap logic takes it.
  a_trap_hold: assert property (o_trap_req && !i_trap_taken
    |=> o_trap_req && $stable(o_trap_type)) else $error("trap request dropped early");
  a_trap_release: assert property (o_trap_req && i_trap_taken && i_clk_en
    |=> !o_trap_req && !o_hw_fault_out_n) else $error("trap not released");
  a_type_legal: assert property (o_trap_req |-> o_trap_type inside {[8'h61:8'h66]})
    else $error("bad trap type");
  a_halt_sticky: assert property (!o_error_mode_n |=> !o_error_mode_n && o_halt
    && !o_hw_fault_out_n) else $error("error mode left");
  // Reset must be off at the launching edge, or the flop holds its reset value.
  a_data_par: assert property (i_clk_en && i_rst_n
    |=> o_data_bus_parity == ~^$past(i_store_word)) else $error("data parity wrong");
  a_addr_par: assert property (i_clk_en && i_rst_n
    |=> o_addr_bus_parity == ~^$past(i_addr)) else $error("address parity wrong");
  // The reserved no-operation only acts while flow monitoring is on.
  a_disarm_next: assert property (i_clk_en && o_error_mode_n && (i_trap_taken
    || i_ex_valid && !o_trap_req && (i_ex_instr == 32'h81C8_0000
    || !i_flow_enable_n && i_ex_instr == 32'h0100_0000)) |=> !o_check_armed)
    else $error("check not disarmed");
  a_chk_rearm: assert property (i_clk_en && i_ex_valid && !o_check_armed && !o_trap_req
    && !i_trap_taken && o_error_mode_n && !i_flow_enable_n && i_ex_instr[31:16] == 16'h011F
    |=> o_check_armed) else $error("check not rearmed");
  a_par_trap: assert property (i_clk_en && i_ex_valid && o_hw_fault_out_n && !o_trap_req
    && i_traps_enabled && i_ex_instr_par != ~^i_ex_instr |=> o_trap_req && !o_hw_fault_out_n)
    else $error("parity error not trapped");
endmodule // fspm_chk
bind flow_signature_parity_monitor fspm_chk #(.WORD_W(WORD_W)) chk_u (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_ex_valid(i_ex_valid),
  .i_flow_enable_n(i_flow_enable_n),
  .i_ex_instr(i_ex_instr), .i_ex_instr_par(i_ex_instr_par), .i_store_word(i_store_word),
  .i_addr(i_addr), .i_trap_taken(i_trap_taken), .i_traps_enabled(i_traps_enabled),
  .o_hw_fault_out_n(o_hw_fault_out_n), .o_error_mode_n(o_error_mode_n), .o_halt(o_halt),
  .o_trap_req(o_trap_req), .o_trap_type(o_trap_type), .o_check_armed(o_check_armed),
  .o_data_bus_parity(o_data_bus_parity), .o_addr_bus_parity(o_addr_bus_parity));

// >>> tb/tb_top.sv
`timescale 1ns/100ps
// Drives execute-stage words and error sources; traps are taken by the model.
module tb_top;
  logic clk = 0, rst_n = 0, en = 1, flow_n = 0, valid = 0, ipar = 1, lpar = 1, lused = 0;
  logic rapar = 1, raused = 0, rbpar = 1, rbused = 0, fat = 0, imp = 0, ten = 1;
  logic [31:0] ins = 0, ld = 0, ra = 0, rb = 0, st = 0, ad = 0, cs;
  logic [3:0] dly = 0;
  logic [7:0] ttype;
  logic [15:0] lsig, sig_exp = 0;
  logic taken, fault_n, emode_n, halt, treq, armed, data_bus_parity, addr_bus_parity, prev = 0;
  logic [7:0] exp_q[$]; // Trap codes expected, oldest first.
  int err_count = 0, checks = 0, cyc = 0;
  logic [7:0] codes[5] = '{8'h61, 8'h63, 8'h65, 8'h62, 8'h64};
  int kinds[5] = '{1, 2, 4, 5, 6};
  initial forever #2.5 clk = ~clk;
  flow_signature_parity_monitor dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
    .i_flow_enable_n(flow_n), .i_ex_valid(valid), .i_ex_instr(ins), .i_ex_instr_par(ipar),
    .i_load_word(ld), .i_load_par(lpar), .i_load_used(lused), .i_rf_a_word(ra),
    .i_rf_a_par(rapar), .i_rf_a_used(raused), .i_rf_b_word(rb), .i_rf_b_par(rbpar),
    .i_rf_b_used(rbused), .i_fatal_precise_err(fat), .i_imprecise_err(imp),
    .i_store_word(st), .i_addr(ad), .i_trap_taken(taken), .i_traps_enabled(ten),
    .o_hw_fault_out_n(fault_n), .o_error_mode_n(emode_n), .o_halt(halt), .o_trap_req(treq),
    .o_trap_type(ttype), .o_last_signature(lsig), .o_check_armed(armed),
    .o_data_bus_parity(data_bus_parity), .o_addr_bus_parity(addr_bus_parity));
  trap_logic_model trap_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_trap_req(treq),
    .i_delay(dly), .o_trap_taken(taken));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // A hang is cut short well above the hundred or so cycles the tests need.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 6000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  // Each new trap request consumes the oldest expected code.
  always @(negedge clk)
  begin
    if (treq === 1'b1 && !prev)
      check(ttype, exp_q.size() ? exp_q.pop_front() : 8'h00);
    prev = (treq === 1'b1);
  end
  // Ordinary words use opcode 3 so they never decode as set-high or return.
  function automatic logic [31:0] rw();
    return 32'hC000_0000 | ($urandom & 32'h3FFF_FFFF);
  endfunction
  function automatic logic [31:0] chk(input logic [15:0] s);
    return 32'h011F_0000 | s;
  endfunction
  // Kind selects the error source: 1 instruction, 2 used load, 3 unused load,
  // 4 register operand, 5 fatal precise, 6 imprecise.
  task exec(input logic [31:0] w, input int k);
    logic [31:0] r;
    @(posedge clk);
    valid <= 1;
    ins <= w;
    ipar <= (k == 1) ? ^w : ~^w;
    r = $urandom;
    ld <= r;
    lpar <= (k == 2 || k == 3) ? ^r : ~^r;
    lused <= (k == 2) || (k != 3 && r[0]);
    r = $urandom;
    ra <= r;
    rapar <= (k == 4) ? ^r : ~^r;
    raused <= (k == 4) || r[1];
    r = $urandom;
    rb <= r;
    rbpar <= ~^r;
    rbused <= r[2];
    st <= $urandom;
    ad <= $urandom;
    fat <= (k == 5);
    imp <= (k == 6);
  endtask
  task idle(input int n);
    repeat (n)
    begin
      @(posedge clk);
      valid <= 0;
      fat <= 0;
      imp <= 0;
      lused <= 0;
      raused <= 0;
    end
  endtask
  // After a failing word: fault held, trap taken, then a clean resume.
  task resolve();
    int n;
    idle(1);
    @(negedge clk);
    check(fault_n, 0);
    n = 0;
    while (treq !== 1'b0 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    check(treq, 0);
    exec(32'h81C8_0000, 0);
    exec(rw(), 0);
    idle(1);
    @(negedge clk);
    check(fault_n, 1);
  endtask
  // Random ordinary words, then a matching checkpoint.
  // With monitoring off no comparison happens, so the last signature stays put.
  task flow_ok(input int n, input bit on);
    logic [31:0] w;
    cs = 0;
    repeat (n)
    begin
      w = rw();
      cs ^= w;
      exec(w, 0);
    end
    exec(chk(cs[31:16] ^ cs[15:0]), 0);
    idle(1);
    @(negedge clk);
    if (on)
      sig_exp = cs[31:16] ^ cs[15:0];
    check(lsig, sig_exp);
    check(armed, 1);
  endtask
  initial
  begin
    void'($urandom(32'h9196_b6bb));
    valid = 1;
    ins = 32'hC000_0001;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    valid <= 0;
    @(negedge clk);
    check({fault_n, armed, treq, data_bus_parity, lsig}, {4'b1101, 16'h0000});
    flow_ok(7, 1);
    flow_ok(0, 1);
    exp_q.push_back(8'h66);
    exec(chk(16'h0001), 0);
    resolve();
    check(armed, 0);
    exec(chk(16'hBEEF), 0);
    idle(1);
    @(negedge clk);
    check(armed, 1);
    exec(32'h0100_0000, 0);
    idle(1);
    @(negedge clk);
    check(armed, 0);
    exec(chk(16'h1234), 0);
    foreach (kinds[i])
    begin
      dly <= $urandom % 4;
      exp_q.push_back(codes[i]);
      exec(rw(), kinds[i]);
      resolve();
    end
    exec(rw(), 3);
    exec(chk(16'h0000), 0);
    @(posedge clk) flow_n <= 1;
    flow_ok(3, 0);
    exec(chk(16'h5555), 0);
    idle(2);
    // A frozen clock enable must ignore a failing word entirely.
    en <= 0;
    exec(rw(), 1);
    idle(1);
    en <= 1;
    @(negedge clk);
    check({treq, fault_n}, 2'b01);
    @(posedge clk) flow_n <= 0;
    @(posedge clk) ten <= 0;
    exec(rw(), 1);
    idle(2);
    @(negedge clk);
    check({emode_n, halt, fault_n}, 3'b010);
    // Only a reset leaves error mode and releases the fault output.
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    check({emode_n, halt, fault_n, treq}, 4'b1010);
    check(exp_q.size(), 0);
    report_and_stop();
  end
endmodule // tb_top
